// ===== common/nva_pkg.sv
// constants, enums and timing for the nonvolatile access block
// assumes the core clock runs at 20 MHz and is the only clock
package nva_pkg;

   // ----------------------------------------
   // register select codes on the sfr port
   // ----------------------------------------
   localparam logic [3:0] SEL_TPU  = 4'h0;
   localparam logic [3:0] SEL_TPH  = 4'h1;
   localparam logic [3:0] SEL_TPL  = 4'h2;
   localparam logic [3:0] SEL_TLAT = 4'h3;
   localparam logic [3:0] SEL_UNLK = 4'h4;
   localparam logic [3:0] SEL_CTRL = 4'h5;
   localparam logic [3:0] SEL_ADDR = 4'h6;
   localparam logic [3:0] SEL_DATA = 4'h7;
   localparam logic [3:0] SEL_PFR2 = 4'h8;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int B_RD    = 0;
   localparam int B_WR    = 1;
   localparam int B_WRITE_UNLOCK_ENABLE  = 2;
   localparam int B_ABORT = 3;
   localparam int B_FREE  = 4;
   localparam int B_CFG   = 6;
   localparam int B_MEM   = 7;
   localparam int B_DONE  = 4;
   localparam int TPU_W   = 6;

   // ----------------------------------------
   // values
   // ----------------------------------------
   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [7:0] ERASED     = 8'hff;

   // ----------------------------------------
   // self-timed cycle length
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int WRITE_TIME_US = 4000;
   localparam int WRITE_CYCLES  = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int CNT_W         = 17;

   typedef enum logic [1:0] {
      UNL_IDLE  = 2'b00,
      UNL_HALF  = 2'b01,
      UNL_ARMED = 2'b10
   } nva_unlock_t;

   typedef enum logic [1:0] {
      TGT_DATA  = 2'b00,
      TGT_FLASH = 2'b01,
      TGT_CFG   = 2'b10
   } nva_target_t;

endpackage : nva_pkg

// ===== hdl/nva_nv_engine.sv
// 256-byte data array plus the self-timed erase/write cycle timer
// assumes start comes only while idle and abort is a same-clock level
`timescale 1ns/100ps
module nva_nv_engine #(
   parameter int WR_CYCLES = nva_pkg::WRITE_CYCLES
) (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               start,
   input  wire logic               abort,
   input  wire nva_pkg::nva_target_t tgt,
   input  wire logic [7:0]         addr,
   input  wire logic [7:0]         data,
   input  wire logic [7:0]         rdAddr,
   output logic                    done,
   output logic [7:0]              rdByte
);

   localparam logic [nva_pkg::CNT_W-1:0] LAST = (nva_pkg::CNT_W)'(WR_CYCLES - 1);

   typedef enum logic {
      ENG_IDLE = 1'b0,
      ENG_RUN  = 1'b1
   } nva_eng_t;

   typedef struct packed {
      nva_eng_t                    state;
      logic [nva_pkg::CNT_W-1:0]   cnt;
      logic [7:0]                  addr;
      logic [7:0]                  data;
      nva_pkg::nva_target_t        tgt;
      logic                        done;
   } nva_eng_st_t;

   nva_eng_st_t s_r;
   nva_eng_st_t s_nxt;
   logic [7:0]  mem [256];
   logic        lastTick;

   assign lastTick = (s_r.state == ENG_RUN) && (s_r.cnt == LAST);
   assign done     = s_r.done;
   assign rdByte   = mem[rdAddr];

   // ----------------------------------------
   // timer
   // ----------------------------------------
   always_comb
   begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      case (s_r.state)
         ENG_IDLE:
         begin
            if (start && !abort)
            begin
               s_nxt.state = ENG_RUN;
               s_nxt.cnt   = '0;
               s_nxt.addr  = addr;
               s_nxt.data  = data;
               s_nxt.tgt   = tgt;
            end
         end
         ENG_RUN:
         begin
            if (abort)
               s_nxt.state = ENG_IDLE;
            else if (lastTick)
            begin
               s_nxt.state = ENG_IDLE;
               s_nxt.done  = 1'b1;
            end
            else
               s_nxt.cnt = s_r.cnt + 1'b1;
         end
         default: s_nxt.state = ENG_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // ----------------------------------------
   // array: erase at start, program at end
   // ----------------------------------------
   // an aborted cycle leaves the cell erased, hence reprogram
   always_ff @(posedge clk)
   begin
      if (abort)
         ;
      else if (start && s_r.state == ENG_IDLE && tgt == nva_pkg::TGT_DATA)
         mem[addr] <= nva_pkg::ERASED;
      else if (lastTick && s_r.tgt == nva_pkg::TGT_DATA)
         mem[s_r.addr] <= s_r.data;
   end

endmodule : nva_nv_engine

// ===== hdl/nva_access_ctl.sv
// sfr-side control of data eeprom, flash and config write cycles
// assumes single-cycle sfr writes and a watchdog pulse on clk
`timescale 1ns/100ps
module nva_access_ctl #(
   parameter int WR_CYCLES = nva_pkg::WRITE_CYCLES
) (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic [3:0]         sfrSel,
   input  wire logic               sfrWr,
   input  wire logic [7:0]         sfrWdata,
   output logic [7:0]              sfrRdata,
   input  wire logic               extResetPin,
   input  wire logic               watchdogTimeout,
   output logic [21:0]             tablePointer,
   output logic [7:0]              tableDataLatch,
   output logic                    opBusy,
   output nva_pkg::nva_target_t    opTarget,
   output logic                    opRowErase,
   output logic                    writeDoneIrqFlag
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic                        xrst1;
      logic                        xrst2;
      logic                        memSpaceSelect;
      logic                        configSpaceSelect;
      logic                        rowErase;
      logic                        writeAbortFlag;
      logic                        writeUnlockEnable;
      logic                        wrStart;
      logic                        rdStart;
      logic                        kick;
      nva_pkg::nva_unlock_t        unlock;
      nva_pkg::nva_target_t        tgt;
      logic [7:0]                  addr;
      logic [7:0]                  data;
      logic [nva_pkg::TPU_W-1:0]   tpu;
      logic [7:0]                  tph;
      logic [7:0]                  tpl;
      logic [7:0]                  tlat;
      logic                        doneFlag;
      logic [7:0]                  rdData;
   } nva_ctl_st_t;

   nva_ctl_st_t s_r;
   nva_ctl_st_t s_nxt;
   logic        opDone;
   logic        abortReq;
   logic [7:0]  rdByte;

   // bit 5 is never stored, so it cannot read back as one
   function automatic logic [7:0] ctrlByte(input nva_ctl_st_t s);
      ctrlByte = {s.memSpaceSelect, s.configSpaceSelect, 1'b0, s.rowErase,
                  s.writeAbortFlag, s.writeUnlockEnable, s.wrStart, s.rdStart};
   endfunction : ctrlByte

   function automatic nva_pkg::nva_target_t pickTarget(input logic mem,
                                                       input logic cfg);
      if (cfg)
         pickTarget = nva_pkg::TGT_CFG;
      else if (mem)
         pickTarget = nva_pkg::TGT_FLASH;
      else
         pickTarget = nva_pkg::TGT_DATA;
   endfunction : pickTarget

   // watchdog is on clk already; the pin arrives through xrst2 only
   assign abortReq = s_r.xrst2 | watchdogTimeout;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      s_nxt        = s_r;
      s_nxt.xrst1  = extResetPin;
      s_nxt.xrst2  = s_r.xrst1;
      s_nxt.kick   = 1'b0;
      s_nxt.rdStart = 1'b0;
      if (s_r.rdStart)
         s_nxt.data = rdByte;

      case (sfrSel)
         nva_pkg::SEL_TPU:  s_nxt.rdData = {2'b00, s_r.tpu};
         nva_pkg::SEL_TPH:  s_nxt.rdData = s_r.tph;
         nva_pkg::SEL_TPL:  s_nxt.rdData = s_r.tpl;
         nva_pkg::SEL_TLAT: s_nxt.rdData = s_r.tlat;
         nva_pkg::SEL_UNLK: s_nxt.rdData = nva_pkg::RST_BYTE;
         nva_pkg::SEL_CTRL: s_nxt.rdData = ctrlByte(s_r);
         nva_pkg::SEL_ADDR: s_nxt.rdData = s_r.addr;
         nva_pkg::SEL_DATA: s_nxt.rdData = s_r.data;
         nva_pkg::SEL_PFR2: s_nxt.rdData = {3'b000, s_r.doneFlag, 4'h0};
         default:           s_nxt.rdData = nva_pkg::RST_BYTE;
      endcase

      if (sfrWr)
      begin
         // any write other than the key bytes breaks the sequence
         s_nxt.unlock = nva_pkg::UNL_IDLE;
         case (sfrSel)
            nva_pkg::SEL_TPU:  s_nxt.tpu  = sfrWdata[nva_pkg::TPU_W-1:0];
            nva_pkg::SEL_TPH:  s_nxt.tph  = sfrWdata;
            nva_pkg::SEL_TPL:  s_nxt.tpl  = sfrWdata;
            nva_pkg::SEL_TLAT: s_nxt.tlat = sfrWdata;
            nva_pkg::SEL_UNLK:
            begin
               if (sfrWdata == nva_pkg::KEY_FIRST)
                  s_nxt.unlock = nva_pkg::UNL_HALF;
               else if (sfrWdata == nva_pkg::KEY_SECOND && s_r.unlock == nva_pkg::UNL_HALF)
                  s_nxt.unlock = nva_pkg::UNL_ARMED;
            end
            nva_pkg::SEL_ADDR:
            begin
               if (!s_r.wrStart)
                  s_nxt.addr = sfrWdata;
            end
            nva_pkg::SEL_DATA:
            begin
               if (!s_r.wrStart)
                  s_nxt.data = sfrWdata;
            end
            nva_pkg::SEL_PFR2: s_nxt.doneFlag = sfrWdata[nva_pkg::B_DONE];
            nva_pkg::SEL_CTRL:
            begin
               if (!s_r.wrStart)
               begin
                  s_nxt.memSpaceSelect    = sfrWdata[nva_pkg::B_MEM];
                  s_nxt.configSpaceSelect = sfrWdata[nva_pkg::B_CFG];
                  s_nxt.rowErase          = sfrWdata[nva_pkg::B_FREE];
                  s_nxt.writeAbortFlag    = sfrWdata[nva_pkg::B_ABORT];
                  s_nxt.writeUnlockEnable = sfrWdata[nva_pkg::B_WRITE_UNLOCK_ENABLE];
                  if (sfrWdata[nva_pkg::B_RD] && !sfrWdata[nva_pkg::B_MEM]
                      && !sfrWdata[nva_pkg::B_CFG])
                     s_nxt.rdStart = 1'b1;
                  if (sfrWdata[nva_pkg::B_WR])
                  begin
                     // old enable only: enable and start in one write fails
                     if (s_r.writeUnlockEnable && s_r.unlock == nva_pkg::UNL_ARMED)
                     begin
                        s_nxt.wrStart = 1'b1;
                        s_nxt.kick    = 1'b1;
                        s_nxt.tgt     = pickTarget(sfrWdata[nva_pkg::B_MEM],
                                                   sfrWdata[nva_pkg::B_CFG]);
                     end
                     // selects stay as written so the failed op is traceable
                     s_nxt.writeAbortFlag = 1'b1;
                  end
               end
            end
            default: ;
         endcase
      end

      // completion after the sfr writes so the done flag set wins
      if (opDone)
      begin
         s_nxt.wrStart        = 1'b0;
         s_nxt.rowErase       = 1'b0;
         s_nxt.writeAbortFlag = 1'b0;
         s_nxt.doneFlag       = 1'b1;
      end

      // a reset mid-cycle kills the cycle but keeps the abort flag
      if (abortReq)
      begin
         s_nxt.wrStart           = 1'b0;
         s_nxt.kick              = 1'b0;
         s_nxt.rdStart           = 1'b0;
         s_nxt.rowErase          = 1'b0;
         s_nxt.writeUnlockEnable = 1'b0;
         s_nxt.unlock            = nva_pkg::UNL_IDLE;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // ----------------------------------------
   // array and cycle timer
   // ----------------------------------------
   nva_nv_engine #(
      .WR_CYCLES (WR_CYCLES)
   ) u_engine (
      .clk    (clk),
      .rst    (rst),
      .start  (s_r.kick),
      .abort  (abortReq),
      .tgt    (s_r.tgt),
      .addr   (s_r.addr),
      .data   (s_r.data),
      .rdAddr (s_r.addr),
      .done   (opDone),
      .rdByte (rdByte)
   );

   assign sfrRdata         = s_r.rdData;
   assign tablePointer     = {s_r.tpu, s_r.tph, s_r.tpl};
   assign tableDataLatch   = s_r.tlat;
   assign opBusy           = s_r.wrStart;
   assign opTarget         = s_r.tgt;
   assign opRowErase       = s_r.rowErase;
   assign writeDoneIrqFlag = s_r.doneFlag;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_ctrlWr;
      sfrWr && sfrSel == nva_pkg::SEL_CTRL;
   endsequence

   sequence s_started;
      !s_r.wrStart ##1 s_r.wrStart;
   endsequence

   property p_resetAbort;
      s_r.wrStart && watchdogTimeout |=> !s_r.wrStart && s_r.writeAbortFlag;
   endproperty
   a_resetAbort: assert property (p_resetAbort)
      else $error("reset abort lost the abort flag");

   property p_needUnlock;
      s_started |-> $past(s_r.unlock) == nva_pkg::UNL_ARMED && $past(s_r.writeUnlockEnable);
   endproperty
   a_needUnlock: assert property (p_needUnlock)
      else $error("write started without unlock or enable");

   property p_startFlag;
      s_started |-> s_r.writeAbortFlag && s_r.kick;
   endproperty
   a_startFlag: assert property (p_startFlag)
      else $error("start did not raise abort flag and kick");

   property p_finish;
      opDone && !abortReq |=> !s_r.wrStart && !s_r.writeAbortFlag && s_r.doneFlag;
   endproperty
   a_finish: assert property (p_finish)
      else $error("completion not reflected in flags");

   property p_readCycle;
      s_r.rdStart |=> !s_r.rdStart && s_r.data == $past(rdByte);
   endproperty
   a_readCycle: assert property (p_readCycle)
      else $error("read did not land in data register");

   property p_readBlocked;
      s_r.rdStart |-> !s_r.memSpaceSelect && !s_r.configSpaceSelect;
   endproperty
   a_readBlocked: assert property (p_readBlocked)
      else $error("read started for flash or config");

   property p_locked;
      s_r.wrStart && !opDone && !abortReq |=> $stable(s_r.addr) && $stable(s_r.memSpaceSelect);
   endproperty
   a_locked: assert property (p_locked)
      else $error("register changed during write cycle");

   property p_unlockReads;
      sfrSel == nva_pkg::SEL_UNLK |=> sfrRdata == nva_pkg::RST_BYTE;
   endproperty
   a_unlockReads: assert property (p_unlockReads)
      else $error("unlock port read nonzero");

   property p_bitFive;
      s_ctrlWr ##1 sfrSel == nva_pkg::SEL_CTRL |=> !sfrRdata[5];
   endproperty
   a_bitFive: assert property (p_bitFive)
      else $error("control bit 5 read as one");

endmodule : nva_access_ctl

// ===== testbench/nva_core_model.sv
// firmware-side model: drives the sfr port the way the core does
// assumes sfr writes are taken on the rising edge with sfrWr high
`timescale 1ns/100ps
module nva_core_model (
   input  wire logic       clk,
   input  wire logic [7:0] sfrRdata,
   output logic [3:0]      sfrSel,
   output logic            sfrWr,
   output logic [7:0]      sfrWdata
);
   // ----------------------------------------
   // bus tasks, all changes on the falling edge
   // ----------------------------------------
   initial
   begin
      sfrSel   = 4'h0;
      sfrWr    = 1'b0;
      sfrWdata = 8'h00;
   end

   // one idle cycle after each write, so the strobe never toggles twice at once
   task automatic wr(input logic [3:0] sel, input logic [7:0] val);
      @(negedge clk);
      sfrSel   = sel;
      sfrWdata = val;
      sfrWr    = 1'b1;
      @(negedge clk);
      sfrWr    = 1'b0;
      sfrWdata = ~val;
   endtask : wr

   task automatic rd(input logic [3:0] sel, output logic [7:0] val);
      @(negedge clk);
      sfrSel = sel;
      repeat (2) @(posedge clk);
      @(negedge clk);
      val = sfrRdata;
   endtask : rd

   task automatic unlock();
      wr(nva_pkg::SEL_UNLK, nva_pkg::KEY_FIRST);
      wr(nva_pkg::SEL_UNLK, nva_pkg::KEY_SECOND);
   endtask : unlock
endmodule : nva_core_model

// ===== testbench/testbench.sv
// self-checking bench for the nonvolatile access control block
// assumes nva_core_model plays the firmware on the sfr port
`timescale 1ns/100ps
module testbench;
   typedef struct packed {logic [3:0] sel; logic [7:0] wv; logic [7:0] ex;} nva_row_t;

   logic        clk;
   logic        rst;
   logic        extResetPin;
   logic        watchdogTimeout;
   logic [3:0]  sfrSel;
   logic        sfrWr;
   logic [7:0]  sfrWdata;
   logic [7:0]  sfrRdata;
   logic [21:0] tablePointer;
   logic [7:0]  tableDataLatch;
   logic        opBusy;
   logic        opRowErase;
   logic        writeDoneIrqFlag;
   logic [7:0]  v;
   nva_pkg::nva_target_t opTarget;
   nva_row_t    rows [8];
   int          fail_count = 0;
   int          checks_done = 0;

   // short cycle so the self-timed write fits the run
   nva_access_ctl #(.WR_CYCLES(24)) nva_access_ctl_i (
      .clk(clk), .rst(rst), .sfrSel(sfrSel), .sfrWr(sfrWr), .sfrWdata(sfrWdata),
      .sfrRdata(sfrRdata), .extResetPin(extResetPin), .watchdogTimeout(watchdogTimeout),
      .tablePointer(tablePointer), .tableDataLatch(tableDataLatch), .opBusy(opBusy),
      .opTarget(opTarget), .opRowErase(opRowErase), .writeDoneIrqFlag(writeDoneIrqFlag));

   nva_core_model nva_core_model_i (
      .clk(clk), .sfrRdata(sfrRdata), .sfrSel(sfrSel), .sfrWr(sfrWr), .sfrWdata(sfrWdata));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checks_done++;
      if (got !== ex)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   task automatic w(input logic [3:0] s, input logic [7:0] d);
      nva_core_model_i.wr(s, d);
   endtask : w

   task automatic start(input logic [7:0] base);
      w(nva_pkg::SEL_CTRL, base);
      nva_core_model_i.unlock();
      w(nva_pkg::SEL_CTRL, base | 8'h02);
      @(negedge clk);
   endtask : start

   task automatic wait_idle();
      for (int i = 0; i < 100 && opBusy !== 1'b0; i++)
         @(negedge clk);
      chk("opBusy end", 0, opBusy);
   endtask : wait_idle

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------
   // clock, watchdog, tests
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      fail_count++;
      $display("ERROR watchdog expected finish seen hang");
      tally_and_finish();
   end

   initial
   begin
      rows[0] = {nva_pkg::SEL_TPU, 8'hff, 8'h3f};
      rows[1] = {nva_pkg::SEL_TPH, 8'ha5, 8'ha5};
      rows[2] = {nva_pkg::SEL_TPL, 8'h5a, 8'h5a};
      rows[3] = {nva_pkg::SEL_TLAT, 8'h3c, 8'h3c};
      rows[4] = {nva_pkg::SEL_UNLK, 8'h55, 8'h00};
      rows[5] = {nva_pkg::SEL_ADDR, 8'hff, 8'hff};
      rows[6] = {nva_pkg::SEL_DATA, 8'hc3, 8'hc3};
      rows[7] = {nva_pkg::SEL_CTRL, 8'he0, 8'hc0};
      rst = 1'b1;
      extResetPin = 1'b0;
      watchdogTimeout = 1'b0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      nva_core_model_i.rd(nva_pkg::SEL_CTRL, v);
      chk("ctrl reset", 8'h00, v);
      chk("busy reset", 0, opBusy);
      chk("done reset", 0, writeDoneIrqFlag);
      $display("reset test done");
      foreach (rows[i])
      begin
         w(rows[i].sel, rows[i].wv);
         nva_core_model_i.rd(rows[i].sel, v);
         chk("row readback", rows[i].ex, v);
      end
      chk("tablePointer", 22'h3fa55a, tablePointer);
      chk("tableDataLatch", 8'h3c, tableDataLatch);
      $display("register table done");
      // eeprom write at top address, with locked registers meanwhile
      start(8'h04);
      chk("busy start", 1, opBusy);
      nva_core_model_i.rd(nva_pkg::SEL_CTRL, v);
      chk("ctrl busy", 8'h0e, v);
      w(nva_pkg::SEL_ADDR, 8'h11);
      w(nva_pkg::SEL_CTRL, 8'h00);
      wait_idle();
      nva_core_model_i.rd(nva_pkg::SEL_CTRL, v);
      chk("ctrl done", 8'h04, v);
      nva_core_model_i.rd(nva_pkg::SEL_ADDR, v);
      chk("addr locked", 8'hff, v);
      chk("target data", nva_pkg::TGT_DATA, opTarget);
      nva_core_model_i.rd(nva_pkg::SEL_PFR2, v);
      chk("done flag", 8'h10, v);
      w(nva_pkg::SEL_DATA, 8'h00);
      w(nva_pkg::SEL_CTRL, 8'h01);
      nva_core_model_i.rd(nva_pkg::SEL_DATA, v);
      chk("read byte", 8'hc3, v);
      nva_core_model_i.rd(nva_pkg::SEL_CTRL, v);
      chk("read self clear", 8'h00, v);
      chk("done sticky", 1, writeDoneIrqFlag);
      w(nva_pkg::SEL_PFR2, 8'h00);
      @(negedge clk);
      chk("done cleared", 0, writeDoneIrqFlag);
      $display("eeprom write test done");
      // improper starts: no unlock, then enable in the same write
      w(nva_pkg::SEL_CTRL, 8'h04);
      w(nva_pkg::SEL_CTRL, 8'h06);
      nva_core_model_i.rd(nva_pkg::SEL_CTRL, v);
      chk("no unlock busy", 0, opBusy);
      chk("no unlock abort", 8'h08, v & 8'h0a);
      w(nva_pkg::SEL_CTRL, 8'h00);
      nva_core_model_i.unlock();
      w(nva_pkg::SEL_CTRL, 8'h06);
      nva_core_model_i.rd(nva_pkg::SEL_CTRL, v);
      chk("same write busy", 0, opBusy);
      chk("same write abort", 8'h08, v & 8'h0a);
      $display("improper start test done");
      // flash row erase, then config target
      start(8'h94);
      chk("target flash", nva_pkg::TGT_FLASH, opTarget);
      chk("row erase", 1, opRowErase);
      wait_idle();
      chk("row erase clear", 0, opRowErase);
      nva_core_model_i.rd(nva_pkg::SEL_CTRL, v);
      chk("ctrl flash done", 8'h84, v);
      start(8'hc4);
      chk("target cfg", nva_pkg::TGT_CFG, opTarget);
      wait_idle();
      $display("flash and config test done");
      // read start must be ignored outside the data space
      w(nva_pkg::SEL_DATA, 8'h77);
      w(nva_pkg::SEL_CTRL, 8'h81);
      nva_core_model_i.rd(nva_pkg::SEL_DATA, v);
      chk("read ignored mem", 8'h77, v);
      w(nva_pkg::SEL_CTRL, 8'h41);
      nva_core_model_i.rd(nva_pkg::SEL_DATA, v);
      chk("read ignored cfg", 8'h77, v);
      $display("read refusal test done");
      // aborts by watchdog and by the reset pin mid-cycle
      start(8'h84);
      watchdogTimeout = 1'b1;
      @(negedge clk);
      watchdogTimeout = 1'b0;
      repeat (2) @(negedge clk);
      chk("wdt abort busy", 0, opBusy);
      nva_core_model_i.rd(nva_pkg::SEL_CTRL, v);
      chk("wdt abort ctrl", 8'h88, v);
      start(8'h04);
      extResetPin = 1'b1;
      repeat (4) @(negedge clk);
      extResetPin = 1'b0;
      repeat (2) @(negedge clk);
      chk("pin abort busy", 0, opBusy);
      nva_core_model_i.rd(nva_pkg::SEL_CTRL, v);
      chk("pin abort ctrl", 8'h08, v);
      // cut cycle never programs, so the byte stays erased
      w(nva_pkg::SEL_CTRL, 8'h01);
      nva_core_model_i.rd(nva_pkg::SEL_DATA, v);
      chk("abort erased", 8'hff, v);
      $display("abort test done");
      // power-on reset in mid-cycle clears every register but the data array
      start(8'h04);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      nva_core_model_i.rd(nva_pkg::SEL_CTRL, v);
      chk("por ctrl", 8'h00, v);
      chk("por busy", 0, opBusy);
      $display("mid-run reset test done");
      tally_and_finish();
   end
endmodule : testbench
